// ==== rtl/vpt_vc3_trail_termination.sv ====
`timescale 1ns/1ns
module vpt_vc3_trail_termination
    import vpt_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [7:0]        paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              tx_valid_i,
    input  wire logic              tx_sof_i,
    input  wire logic [7:0]        tx_data_i,
    output logic                   tx_valid_o,
    output logic                   tx_sof_o,
    output logic      [7:0]        tx_data_o,
    input  wire logic              rx_valid_i,
    input  wire logic              rx_sof_i,
    input  wire logic [7:0]        rx_data_i,
    input  wire logic              second_i,
    output logic                   tim_o,
    output logic                   uneq_o,
    output logic                   report_o
);
    if (CNT_W < 13 || CNT_W > 31) begin : g_chk
        $error("CNT_W must lie in 13..31");
    end

    function automatic logic [10:0] advance(input logic [10:0] pos);
        // Position packs row in [10:7] and column in [6:0]
        if (pos[6:0] == 7'(VPT_COLS - 1) && pos[10:7] == 4'(VPT_ROWS - 1)) begin
            // Wrap after the last byte so that a complete frame lands on zero
            advance = 11'h000;
        end else if (pos[6:0] == 7'(VPT_COLS - 1)) begin
            advance = {pos[10:7] + 4'h1, 7'h00};
        end else begin
            advance = {pos[10:7], pos[6:0] + 7'h01};
        end
    endfunction : advance

    function automatic logic is_oh(input logic [10:0] pos, input logic [3:0] row);
        is_oh = (pos[6:0] == 7'h00) && (pos[10:7] == row);
    endfunction : is_oh

    // Configuration
    logic              ctrl_mon;
    logic              ctrl_uni;
    logic [7:0]        tx_trace;
    logic [7:0]        ex_trace;
    // Source state
    logic [10:0]       tx_next;
    logic [10:0]       tx_pos;
    logic [7:0]        tx_byte;
    logic [7:0]        tx_bip_acc;
    logic [7:0]        tx_bip_prev;
    // Sink state
    logic [10:0]       rx_next;
    logic [10:0]       rx_pos;
    logic [7:0]        rx_bip_acc;
    logic [7:0]        rx_bip_prev;
    logic              rx_prev_ok;
    logic              rx_seen;
    logic [7:0]        rx_diff;
    logic [3:0]        rx_errs;
    logic [3:0]        rei_send;
    logic              tim_raw;
    logic              uneq_raw;
    logic              rdi_rx;
    logic              near_err_ev;
    logic              far_err_ev;
    // One-second monitoring
    logic [CNT_W-1:0]  near_cnt;
    logic [CNT_W-1:0]  far_cnt;
    logic              near_ds;
    logic              far_ds;
    logic [CNT_W-1:0]  near_rep;
    logic [CNT_W-1:0]  far_rep;
    logic              near_ds_rep;
    logic              far_ds_rep;
    // Bus
    logic              apb_write;
    logic              apb_first;
    logic [31:0]       next_rdata;
    logic              next_err;

    // Source: frame position of the current byte
    assign tx_pos = tx_sof_i ? 11'h000 : tx_next;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_next <= 11'h000;
        end else if (tx_valid_i) begin
            tx_next <= advance(tx_pos);
        end
    end

    always_comb begin
        tx_byte = tx_data_i;
        if (is_oh(tx_pos, ROW_TRACE)) begin
            tx_byte = tx_trace;
        end else if (is_oh(tx_pos, ROW_PARITY)) begin
            tx_byte = tx_bip_prev;
        end else if (is_oh(tx_pos, ROW_STATUS)) begin
            if (ctrl_uni) begin
                tx_byte = 8'h00;
            end else begin
                tx_byte = {rei_send, tim_raw | uneq_raw, 3'h0};
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_bip_acc  <= 8'h00;
            tx_bip_prev <= 8'h00;
        end else if (tx_valid_i) begin
            if (tx_sof_i) begin
                tx_bip_prev <= tx_bip_acc;
                tx_bip_acc  <= tx_byte;
            end else begin
                tx_bip_acc  <= tx_bip_acc ^ tx_byte;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_valid_o <= 1'b0;
            tx_sof_o   <= 1'b0;
            tx_data_o  <= 8'h00;
        end else begin
            tx_valid_o <= tx_valid_i;
            tx_sof_o   <= tx_valid_i & tx_sof_i;
            tx_data_o  <= tx_valid_i ? tx_byte : 8'h00;
        end
    end

    // Sink: position and parity
    assign rx_pos  = rx_sof_i ? 11'h000 : rx_next;
    assign rx_diff = rx_bip_prev ^ rx_data_i;

    always_comb begin
        rx_errs = 4'h0;
        for (int i = 0; i < 8; i++) begin
            rx_errs = rx_errs + {3'h0, rx_diff[i]};
        end
    end

    assign near_err_ev = rx_valid_i && rx_prev_ok && is_oh(rx_pos, ROW_PARITY)
                         && (rx_diff != 8'h00);
    assign far_err_ev  = rx_valid_i && !ctrl_uni && is_oh(rx_pos, ROW_STATUS)
                         && (rx_data_i[G1_REI_HI:G1_REI_LO] != 4'h0)
                         && (rx_data_i[G1_REI_HI:G1_REI_LO] <= REI_MAX);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_next     <= 11'h000;
            rx_bip_acc  <= 8'h00;
            rx_bip_prev <= 8'h00;
            rx_prev_ok  <= 1'b0;
            rx_seen     <= 1'b0;
        end else if (rx_valid_i) begin
            rx_next <= advance(rx_pos);
            if (rx_sof_i) begin
                // No parity check on the first frame after reset: nothing precedes it
                rx_bip_prev <= rx_bip_acc;
                rx_bip_acc  <= rx_data_i;
                rx_prev_ok  <= rx_seen && (rx_next == 11'h000);
                rx_seen     <= 1'b1;
            end else begin
                rx_bip_acc  <= rx_bip_acc ^ rx_data_i;
            end
        end
    end

    // Sink: overhead evaluation; rows beyond the status byte are ignored
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rei_send <= 4'h0;
            tim_raw  <= 1'b0;
            uneq_raw <= 1'b0;
            rdi_rx   <= 1'b0;
        end else begin
            if (ctrl_uni) begin
                rdi_rx <= 1'b0;
            end
            if (rx_valid_i) begin
                if (is_oh(rx_pos, ROW_TRACE)) begin
                    tim_raw <= rx_data_i != ex_trace;
                end
                if (is_oh(rx_pos, ROW_PARITY) && rx_prev_ok) begin
                    rei_send <= rx_errs;
                end
                if (is_oh(rx_pos, ROW_LABEL)) begin
                    uneq_raw <= rx_data_i == LABEL_UNEQ;
                end
                if (is_oh(rx_pos, ROW_STATUS) && !ctrl_uni) begin
                    rdi_rx <= rx_data_i[G1_RDI_BIT];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tim_o  <= 1'b0;
            uneq_o <= 1'b0;
        end else begin
            tim_o  <= ctrl_mon & tim_raw;
            uneq_o <= ctrl_mon & uneq_raw;
        end
    end

    // One-second filters; an event in the closing cycle opens the new interval
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            near_cnt <= '0;
            far_cnt  <= '0;
            near_ds  <= 1'b0;
            far_ds   <= 1'b0;
        end else if (second_i) begin
            near_cnt <= CNT_W'(near_err_ev);
            far_cnt  <= CNT_W'(far_err_ev);
            near_ds  <= tim_raw | uneq_raw;
            far_ds   <= rdi_rx & !ctrl_uni;
        end else begin
            near_cnt <= near_cnt + CNT_W'(near_err_ev);
            far_cnt  <= far_cnt + CNT_W'(far_err_ev);
            near_ds  <= near_ds | tim_raw | uneq_raw;
            far_ds   <= far_ds | (rdi_rx & !ctrl_uni);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            near_rep    <= '0;
            far_rep     <= '0;
            near_ds_rep <= 1'b0;
            far_ds_rep  <= 1'b0;
            report_o    <= 1'b0;
        end else begin
            report_o <= second_i & ctrl_mon;
            if (second_i && ctrl_mon) begin
                near_rep    <= near_cnt;
                far_rep     <= far_cnt;
                near_ds_rep <= near_ds;
                far_ds_rep  <= far_ds;
            end
        end
    end

    // APB slave: one wait state, write and read both complete on pready
    assign apb_first = psel_i & penable_i & ~pready_o;
    assign apb_write = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (paddr_i)
            OFF_CTRL:     next_rdata = {30'h0, ctrl_uni, ctrl_mon};
            OFF_TX_TRACE: next_rdata = {24'h0, tx_trace};
            OFF_EX_TRACE: next_rdata = {24'h0, ex_trace};
            OFF_STATUS:   next_rdata = {29'h0, rdi_rx, uneq_o, tim_o};
            OFF_NEAR_PM:  next_rdata = 32'(near_rep) | (32'(near_ds_rep) << PM_DS_BIT);
            OFF_FAR_PM:   next_rdata = 32'(far_rep) | (32'(far_ds_rep) << PM_DS_BIT);
            default:      next_err   = 1'b1;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= apb_first;
            pslverr_o <= apb_first & next_err;
            if (apb_first && !pwrite_i) begin
                prdata_o <= next_rdata;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_mon <= CTRL_RESET[CTRL_MON_BIT];
            ctrl_uni <= CTRL_RESET[CTRL_UNI_BIT];
            tx_trace <= TRACE_RESET;
            ex_trace <= TRACE_RESET;
        end else if (apb_write) begin
            case (paddr_i)
                OFF_CTRL: begin
                    ctrl_mon <= pwdata_i[CTRL_MON_BIT];
                    ctrl_uni <= pwdata_i[CTRL_UNI_BIT];
                end
                OFF_TX_TRACE: tx_trace <= pwdata_i[7:0];
                OFF_EX_TRACE: ex_trace <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    a_trace_insert: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_valid_i && tx_sof_i |=> tx_data_o == $past(tx_trace))
        else $error("trace byte not inserted");
    a_parity_insert: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_valid_i && is_oh(tx_pos, ROW_PARITY) |=> tx_data_o == $past(tx_bip_prev))
        else $error("parity byte not inserted");
    a_status_uni: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_valid_i && ctrl_uni && is_oh(tx_pos, ROW_STATUS) |=> tx_data_o == 8'h00)
        else $error("status byte not zero");
    a_status_rdi: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_valid_i && !ctrl_uni && is_oh(tx_pos, ROW_STATUS)
        |=> tx_data_o[G1_RDI_BIT] == $past(tim_raw | uneq_raw))
        else $error("remote defect bit wrong");
    a_defect_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !ctrl_mon ##1 !ctrl_mon |-> !tim_o && !uneq_o)
        else $error("defect reported while unmonitored");
    a_uneq_detect: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rx_valid_i && is_oh(rx_pos, ROW_LABEL) && rx_data_i == LABEL_UNEQ
        ##1 ctrl_mon |=> uneq_o)
        else $error("unequipped label missed");
    a_report_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
        second_i && !ctrl_mon |=> !report_o && $stable(near_rep))
        else $error("report while unmonitored");
    a_far_uni: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ctrl_uni |-> !far_err_ev ##1 (second_i || !$rose(far_ds)))
        else $error("far-end processing in unidirectional mode");
    a_near_restart: assert property (@(posedge clk_i) disable iff (!resetn_i)
        second_i |=> near_cnt == CNT_W'($past(near_err_ev)))
        else $error("near count not restarted");
endmodule : vpt_vc3_trail_termination

// ==== rtl/vpt_pkg.sv ====
package vpt_pkg;
    // Frame geometry
    localparam int          VPT_ROWS     = 9;
    localparam int          VPT_COLS     = 85;
    // Overhead rows in column zero
    localparam logic [3:0]  ROW_TRACE    = 4'h0;
    localparam logic [3:0]  ROW_PARITY   = 4'h1;
    localparam logic [3:0]  ROW_LABEL    = 4'h2;
    localparam logic [3:0]  ROW_STATUS   = 4'h3;
    // Path status byte layout (first transmitted bit is bit 7)
    localparam int          G1_REI_HI    = 7;
    localparam int          G1_REI_LO    = 4;
    localparam int          G1_RDI_BIT   = 3;
    localparam logic [3:0]  REI_MAX      = 4'h8;
    localparam logic [7:0]  LABEL_UNEQ   = 8'h00;
    // Register byte offsets
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_TX_TRACE = 8'h04;
    localparam logic [7:0]  OFF_EX_TRACE = 8'h08;
    localparam logic [7:0]  OFF_STATUS   = 8'h0C;
    localparam logic [7:0]  OFF_NEAR_PM  = 8'h10;
    localparam logic [7:0]  OFF_FAR_PM   = 8'h14;
    // Control fields and reset values
    localparam int          CTRL_MON_BIT = 0;
    localparam int          CTRL_UNI_BIT = 1;
    localparam logic [1:0]  CTRL_RESET   = 2'h0;
    localparam logic [7:0]  TRACE_RESET  = 8'h00;
    // Flag position in the monitoring report words
    localparam int          PM_DS_BIT    = 31;
endpackage : vpt_pkg

// ==== dv/vpt_path_src.sv ====
`timescale 1ns/1ns
module vpt_path_src (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       start_i,
    input  wire logic [7:0] trace_i,
    input  wire logic [7:0] label_i,
    input  wire logic [7:0] status_i,
    input  wire logic [7:0] corrupt_i,
    output logic            valid_o,
    output logic            sof_o,
    output logic      [7:0] data_o,
    output logic            busy_o
);
    logic [9:0] pos;
    logic [7:0] acc;
    logic [7:0] prev;
    logic [7:0] b;

    always_comb begin
        case (pos)
            10'd0:   b = trace_i;
            10'd85:  b = prev ^ corrupt_i;
            10'd170: b = label_i;
            10'd255: b = status_i;
            default: b = pos[7:0] ^ 8'hA5;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pos     <= 10'd0;
            acc     <= 8'h00;
            prev    <= 8'h00;
            valid_o <= 1'b0;
            sof_o   <= 1'b0;
            data_o  <= 8'h00;
            busy_o  <= 1'b0;
        end else if (busy_o || start_i) begin
            valid_o <= 1'b1;
            sof_o   <= (pos == 10'd0);
            data_o  <= b;
            acc     <= (pos == 10'd0) ? b : acc ^ b;
            busy_o  <= (pos != 10'd764);
            pos     <= (pos == 10'd764) ? 10'd0 : pos + 10'd1;
            if (pos == 10'd764) begin
                prev <= acc ^ b;
            end
        end else begin
            // Idle line inverts the last byte and then toggles every bit each cycle
            valid_o <= 1'b0;
            sof_o   <= 1'b0;
            data_o  <= ~data_o;
        end
    end
endmodule : vpt_path_src

// ==== dv/vpt_vc3_trail_termination_test.sv ====
`timescale 1ns/1ns
module vpt_vc3_trail_termination_test;
    import vpt_pkg::*;
    logic        clk_i = 1'b0;
    logic        resetn_i;
    logic        psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata_o;
    logic        pready_o, pslverr_o;
    logic        tx_valid_i, tx_sof_i, tx_valid_o, tx_sof_o;
    logic [7:0]  tx_data_i, tx_data_o;
    logic        rx_valid, rx_sof, src_busy, start;
    logic [7:0]  rx_data, s_trace, s_label, s_status, s_bad;
    logic        second_i, tim_o, uneq_o, report_o;
    logic [8:0]  expq[$];
    logic [8:0]  ex;
    logic [7:0]  tx_par = 8'h00;
    int          fails = 0;
    int          num_checks = 0;
    int          cyc = 0;

    always #50 clk_i = ~clk_i;

    vpt_vc3_trail_termination dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_valid_i(tx_valid_i),
        .tx_sof_i(tx_sof_i), .tx_data_i(tx_data_i), .tx_valid_o(tx_valid_o),
        .tx_sof_o(tx_sof_o), .tx_data_o(tx_data_o), .rx_valid_i(rx_valid),
        .rx_sof_i(rx_sof), .rx_data_i(rx_data), .second_i(second_i), .tim_o(tim_o),
        .uneq_o(uneq_o), .report_o(report_o));

    vpt_path_src src (
        .clk_i(clk_i), .resetn_i(resetn_i), .start_i(start), .trace_i(s_trace),
        .label_i(s_label), .status_i(s_status), .corrupt_i(s_bad), .valid_o(rx_valid),
        .sof_o(rx_sof), .data_o(rx_data), .busy_o(src_busy));

    task automatic results;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // No local timeout: pready or the bench timeout ends this wait
        do @(posedge clk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk("write error", 32'h0, {31'h0, e});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk($sformatf("reg %h", a), exp, r);
    endtask : rd

    task automatic rx(input logic [7:0] t, input logic [7:0] l, input logic [7:0] s,
                      input logic [7:0] bad);
        @(posedge clk_i);
        s_trace  <= t;
        s_label  <= l;
        s_status <= s;
        s_bad    <= bad;
        start    <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        do @(posedge clk_i); while (src_busy);
        repeat (3) @(posedge clk_i);
    endtask : rx

    // Expected output bytes are queued; overhead slots other than the label carry garbage on input
    task automatic tx(input logic [7:0] g1);
        logic [7:0] v;
        logic [7:0] e;
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < 765; i++) begin
            @(posedge clk_i);
            v = (i == 170) ? 8'h13 : 8'(i) ^ 8'h5C;
            e = (i == 0) ? 8'h5A : (i == 85) ? tx_par : (i == 255) ? g1 : v;
            tx_valid_i <= 1'b1;
            tx_sof_i   <= (i == 0);
            tx_data_i  <= v;
            expq.push_back({i == 0, e});
            acc ^= e;
        end
        tx_par = acc;
        @(posedge clk_i);
        tx_valid_i <= 1'b0;
        tx_sof_i   <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : tx

    // Report pulse stands in the cycle after the edge that samples the second pulse
    task automatic second(input logic exp);
        @(posedge clk_i);
        second_i <= 1'b1;
        @(posedge clk_i);
        second_i <= 1'b0;
        @(negedge clk_i);
        chk("report", {31'h0, exp}, {31'h0, report_o});
    endtask : second

    always @(negedge clk_i) begin
        if (tx_valid_o === 1'b1) begin
            ex = (expq.size() > 0) ? expq.pop_front() : 9'h1FF;
            chk("tx sof", {31'h0, ex[8]}, {31'h0, tx_sof_o});
            chk("tx byte", {24'h0, ex[7:0]}, {24'h0, tx_data_o});
        end
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 12000) begin
            fails++;
            results();
        end
    end

    initial begin
        logic [31:0] r;
        logic        e;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {tx_valid_i, tx_sof_i, tx_data_i, second_i, start} = '0;
        {s_trace, s_label, s_status, s_bad} = '0;
        resetn_i = 1'b0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(OFF_CTRL, 32'h0);
        rd(OFF_TX_TRACE, 32'h0);
        rd(OFF_EX_TRACE, 32'h0);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        wr(OFF_TX_TRACE, 32'h5A);
        wr(OFF_EX_TRACE, 32'h3C);
        wr(OFF_CTRL, 32'h1);
        rd(OFF_CTRL, 32'h1);
        rx(8'h3C, 8'h13, 8'h00, 8'h00);
        rx(8'h3C, 8'h13, 8'h2F, 8'h07);
        chk("tim", 32'h0, {31'h0, tim_o});
        tx(8'h30);
        rx(8'h11, 8'h00, 8'h00, 8'h00);
        chk("tim", 32'h1, {31'h0, tim_o});
        chk("uneq", 32'h1, {31'h0, uneq_o});
        rd(OFF_STATUS, 32'h3);
        tx(8'h08);
        second(1'b1);
        rd(OFF_NEAR_PM, 32'h8000_0001);
        rd(OFF_FAR_PM, 32'h8000_0001);
        wr(OFF_CTRL, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("tim", 32'h0, {31'h0, tim_o});
        chk("uneq", 32'h0, {31'h0, uneq_o});
        second(1'b0);
        rd(OFF_NEAR_PM, 32'h8000_0001);
        wr(OFF_CTRL, 32'h3);
        rx(8'h3C, 8'h13, 8'h5F, 8'h00);
        second(1'b1);
        rd(OFF_NEAR_PM, 32'h8000_0000);
        rd(OFF_FAR_PM, 32'h0);
        tx(8'h00);
        chk("tx queue", 32'h0, expq.size());
        results();
    end
endmodule : vpt_vc3_trail_termination_test
